// *** common/ee_config_consts.svh ***
// Constants for the EEPROM configuration, protection and program/erase block
// Notes on behaviour
// - 512-byte array from 0x0800, on-chip pump.
// - Reset copies nonvolatile bytes into volatile registers.
// - Shadow mirrors config byte; software cannot write.
// - High divider: lock bit7, bits2:0, 6:3 zero.
// - 35 us timebase divides crystal or bus clock.
// - Armed secure region refuses changes to 0x08F0-0x08FF.
// - Armed secure region freezes the config byte.
// - Armed secure region blocks block and bulk erase.
// - Armed: unprotected single bytes stay programmable.
// - Four 128-byte blocks, one protect bit each.
// - Protect bits update on reset or config read.
// - Nonvolatile bytes change only by program/erase.
// - Programmed lock bit reloads zero every reset.
// - Lock refuses divider program/erase and writes.
// - Go refused without latch or valid address.
// - Program clears bits only; erase sets ones.
`ifndef EE_CONFIG_CONSTS_SVH
`define EE_CONFIG_CONSTS_SVH

// Register and array word indices (byte address is four times these)
`define A_ARRAY_LO      16'h0800
`define A_ARRAY_HI      16'h09FF
`define A_DIV_NV_HIGH   16'hFE10
`define A_DIV_NV_LOW    16'hFE11
`define A_DIV_HIGH      16'hFE1A
`define A_DIV_LOW       16'hFE1B
`define A_NV_CONFIG     16'hFE1C
`define A_CONTROL       16'hFE1D
`define A_SHADOW        16'hFE1F

// Storage cell indices of the nonvolatile bytes, above the 512 array cells
`define IX_NV_CONFIG    10'h200
`define IX_DIV_NV_HIGH  10'h201
`define IX_DIV_NV_LOW   10'h202
`define STORE_DEPTH     1024

// Array geometry
`define SEC_ROW         5'h0F
`define BLK_LAST        7'h7F
`define BLK_FIRST       7'h00
`define ARR_FIRST       9'h000
`define ARR_LAST        9'h1FF

// Field positions
`define CFG_SECURE      4
`define DIVH_LOCK       7
`define CTL_GO          0
`define CTL_AUTO        1
`define CTL_LATCH       2
`define CTL_ERASE_LO    3
`define CTL_ERASE_HI    4
`define CTL_OFF         5

// Values
`define NV_BLANK        8'hFF
`define NV_CFG_FACTORY  8'hF0
`define ERASED          8'hFF
`define ZERO8           8'h00
`define DIVH_KEEP       8'h87
`define CTL_RESET       8'h00
`define CTL_WMASK       8'h3E
`define DIV_ZERO        11'h000
`define DIV_ONE         11'h001

// Boot load steps
`define BOOT_LD_CFG     2'h1
`define BOOT_LD_DIVH    2'h2
`define BOOT_LD_DIVL    2'h3

// Timing
`define TIMEBASE_NS     35000
`define CLK_PERIOD_NS   10
`define TIMEBASE_CYCLES (`TIMEBASE_NS / `CLK_PERIOD_NS)
`define AUTO_TICKS      3'h4

`endif

// *** common/ee_config_pkg.sv ***
// Types shared by the EEPROM configuration block
package ee_config_pkg;
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_run   = 4'b0010,
    st_apply = 4'b0100,
    st_sweep = 4'b1000
  } pe_state_t;
  typedef enum logic [1:0] {
    em_program = 2'h0,
    em_byte    = 2'h1,
    em_block   = 2'h2,
    em_bulk    = 2'h3
  } erase_mode_t;
endpackage

// *** core/ee_byte_store.sv ***
// Byte store: 512 array cells plus the nonvolatile option bytes
`include "ee_config_consts.svh"
module ee_byte_store (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [9:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [9:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] cells [0:`STORE_DEPTH-1];  // Nonvolatile, never reset

  // Blank parts read all ones; config byte leaves the factory preset
  initial begin
    for (int i = 0; i < `STORE_DEPTH; i++) begin
      cells[i] = `NV_BLANK;
    end
    cells[`IX_NV_CONFIG] = `NV_CFG_FACTORY;
  end

  // One write port, registered read port
  always @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
    rdata <= cells[raddr];
  end
endmodule // ee_byte_store

// *** core/timebase_divider.sv ***
// Timebase divider producing one tick per full count of reference cycles
`include "ee_config_consts.svh"
module timebase_divider (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ref_tick,
  input  wire logic        restart,
  input  wire logic [10:0] divisor,
  output logic             tick
);
  logic [10:0] count_reg;  // Reference cycles seen so far
  logic        tick_reg;   // One-cycle tick

  // Last reference cycle of a period; divisor zero gives no ticks
  wire last = ref_tick && (divisor != `DIV_ZERO) && (count_reg >= divisor - `DIV_ONE);

  // Count up, wrap on a full count, restart on a divisor write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= `DIV_ZERO;
      tick_reg  <= 1'b0;
    end else if (restart) begin
      count_reg <= `DIV_ZERO;
      tick_reg  <= 1'b0;
    end else begin
      tick_reg <= last;
      if (last) begin
        count_reg <= `DIV_ZERO;
      end else if (ref_tick) begin
        count_reg <= count_reg + `DIV_ONE;
      end
    end
  end

  assign tick = tick_reg;
endmodule // timebase_divider

// *** core/ee_config_protect.sv ***
// EEPROM configuration, protection and program/erase engine with Avalon-MM slave
`include "ee_config_consts.svh"
module ee_config_protect
  import ee_config_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        crystal_ref_clock,
  input  wire logic        timebase_ref_select,
  output logic             charge_pump_on
);
  // Pin synchronisers
  logic        xtal_s1_reg;     // First stage, read by second only
  logic        xtal_s2_reg;     // Synchronised crystal level
  logic        xtal_s3_reg;     // Delayed copy for edge detect
  logic        sel_s1_reg;      // First stage of the option strap
  logic        sel_s2_reg;      // Synchronised option strap
  // Bus slave
  logic        wait_reg;        // Registered waitrequest
  logic        stage_reg;       // Read of the store in flight
  logic [31:0] readdata_reg;    // Registered read data
  // Boot loader
  logic        boot_reg;        // Copying option bytes after reset
  logic [1:0]  boot_cnt_reg;    // Boot step
  // Volatile registers
  logic [7:0]  shadow_reg;      // Mirror of the config byte
  logic [7:0]  divh_reg;        // High divider with lock bit
  logic [7:0]  divl_reg;        // Low divider
  logic [7:0]  ctl_reg;         // Control, go bit held in the state
  // Latched target of a program or erase
  logic [9:0]  lat_idx_reg;     // Store index
  logic [7:0]  lat_data_reg;    // Data to program
  logic        lat_valid_reg;   // A valid address was latched
  // Engine
  pe_state_t   state_reg;       // Program/erase state
  logic        refused_reg;     // Current operation is refused
  logic        pump_reg;        // Charge pump enable
  logic [2:0]  auto_cnt_reg;    // Ticks spent in the run state
  logic [8:0]  sweep_idx_reg;   // Cell erased by a block or bulk sweep
  // Store and divider connections
  logic [7:0]  mem_rdata;       // Registered store output
  logic        tick;            // 35 us timebase tick

  // Crystal and strap come from outside: two flops before any use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xtal_s1_reg <= 1'b0;
      xtal_s2_reg <= 1'b0;
      xtal_s3_reg <= 1'b0;
      sel_s1_reg  <= 1'b0;
      sel_s2_reg  <= 1'b0;
    end else begin
      xtal_s1_reg <= crystal_ref_clock;
      xtal_s2_reg <= xtal_s1_reg;
      xtal_s3_reg <= xtal_s2_reg;
      sel_s1_reg  <= timebase_ref_select;
      sel_s2_reg  <= sel_s1_reg;
    end
  end

  // Reference is a crystal rising edge or every bus clock; the crystal
  // must run below half of clk or edges are lost
  wire ref_tick = sel_s2_reg ? (xtal_s2_reg & ~xtal_s3_reg) : 1'b1;

  // Address decode
  wire hit_array  = (avs_address >= `A_ARRAY_LO) && (avs_address <= `A_ARRAY_HI);
  wire hit_nvcfg  = (avs_address == `A_NV_CONFIG);
  wire hit_divnvh = (avs_address == `A_DIV_NV_HIGH);
  wire hit_divnvl = (avs_address == `A_DIV_NV_LOW);
  wire hit_divh   = (avs_address == `A_DIV_HIGH);
  wire hit_divl   = (avs_address == `A_DIV_LOW);
  wire hit_ctl    = (avs_address == `A_CONTROL);
  wire hit_shadow = (avs_address == `A_SHADOW);
  wire hit_mem    = hit_array | hit_nvcfg | hit_divnvh | hit_divnvl;

  // Store index of the bus target
  wire [9:0] bus_idx = hit_array  ? {1'b0, avs_address[8:0]} :
                       hit_nvcfg  ? `IX_NV_CONFIG :
                       hit_divnvh ? `IX_DIV_NV_HIGH : `IX_DIV_NV_LOW;

  // Bus handshake terms
  wire       req     = (avs_read | avs_write) & ~boot_reg;
  wire       rd_load = req & wait_reg & stage_reg;
  wire       answer  = req & ~wait_reg;
  wire       wr_acc  = answer & avs_write & avs_byteenable[0];
  wire [7:0] wd      = avs_writedata[7:0];

  // State of the engine
  wire idle    = (state_reg == st_idle);
  wire running = (state_reg == st_run);
  wire in_sweep = (state_reg == st_sweep);
  erase_mode_t mode;
  assign mode = erase_mode_t'({ctl_reg[`CTL_ERASE_HI], ctl_reg[`CTL_ERASE_LO]});

  // Protection terms
  wire       armed     = ~shadow_reg[`CFG_SECURE];
  wire       locked    = ~divh_reg[`DIVH_LOCK];
  wire       lat_arr   = ~lat_idx_reg[9];
  wire [1:0] blk       = lat_idx_reg[8:7];
  wire       bp_hit    = shadow_reg[blk];
  wire       any_bp    = |shadow_reg[3:0];
  wire       in_sec    = (lat_idx_reg[8:4] == `SEC_ROW);
  wire       wide      = lat_arr & ((mode == em_block) | (mode == em_bulk));
  wire       arr_prot  = wide ? (armed | ((mode == em_bulk) ? any_bp : bp_hit)) :
                         (bp_hit | (armed & in_sec));
  wire       nv_prot   = (lat_idx_reg == `IX_NV_CONFIG) ? armed : locked;
  wire       prot_hit  = lat_arr ? arr_prot : nv_prot;

  // Go may only start with latch set and a valid latched address
  wire go_write = wr_acc & hit_ctl & wd[`CTL_GO];
  wire start    = go_write & idle & ctl_reg[`CTL_LATCH] & lat_valid_reg;
  wire stop_sw  = wr_acc & hit_ctl & ~wd[`CTL_GO] & running;
  wire stop_au  = running & ctl_reg[`CTL_AUTO] & (auto_cnt_reg == `AUTO_TICKS);
  wire sw_last  = (mode == em_bulk) ? (sweep_idx_reg == `ARR_LAST) :
                  (sweep_idx_reg[6:0] == `BLK_LAST);

  // Store ports; programming only ANDs data in, erase writes ones
  wire       mem_we    = ((state_reg == st_apply) & ~refused_reg & ~wide) | in_sweep;
  wire [9:0] mem_waddr = in_sweep ? {1'b0, sweep_idx_reg} : lat_idx_reg;
  wire [7:0] mem_wdata = (~in_sweep & (mode == em_program)) ?
                         (mem_rdata & lat_data_reg) : `ERASED;
  wire [9:0] boot_idx  = (boot_cnt_reg == `BOOT_LD_CFG)  ? `IX_DIV_NV_HIGH :
                         (boot_cnt_reg == `BOOT_LD_DIVH) ? `IX_DIV_NV_LOW : `IX_NV_CONFIG;
  wire [9:0] mem_raddr = boot_reg ? boot_idx : (idle ? bus_idx : lat_idx_reg);

  // Read mux; go bit reads back as the running state
  wire [7:0] ctl_read = {ctl_reg[7:1], running};
  wire [7:0] rd_byte  = hit_mem    ? mem_rdata :
                        hit_divh   ? divh_reg :
                        hit_divl   ? divl_reg :
                        hit_ctl    ? ctl_read :
                        hit_shadow ? shadow_reg : `ZERO8;

  // Divider writes are dropped while the lock is armed
  wire divh_wr = wr_acc & hit_divh & ~locked;
  wire divl_wr = wr_acc & hit_divl & ~locked;
  wire boot_ld = boot_reg & (boot_cnt_reg != `BOOT_LD_CFG - 2'h1);

  ee_byte_store store (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  timebase_divider divider (
    .clk      (clk),
    .reset    (reset),
    .ref_tick (ref_tick),
    .restart  (divh_wr | divl_wr | boot_ld),
    .divisor  ({divh_reg[2:0], divl_reg}),
    .tick     (tick)
  );

  // Bus slave: two wait cycles, then one cycle with waitrequest low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_reg  <= 1'b1;
      stage_reg <= 1'b0;
    end else if (!wait_reg) begin
      wait_reg  <= 1'b1;
      stage_reg <= 1'b0;
    end else if (rd_load) begin
      wait_reg <= 1'b0;
    end else if (req) begin
      stage_reg <= 1'b1;
    end
  end

  // Read data captured once the store output is valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata_reg <= 32'h0000_0000;
    end else if (rd_load) begin
      readdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // Boot: the store is read one step ahead of each load
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_reg     <= 1'b1;
      boot_cnt_reg <= 2'h0;
    end else if (boot_reg) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
      boot_reg     <= (boot_cnt_reg != `BOOT_LD_DIVL);
    end
  end

  // Shadow loads at boot and refreshes on a config byte read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shadow_reg <= `NV_BLANK;
    end else if (boot_reg && boot_cnt_reg == `BOOT_LD_CFG) begin
      shadow_reg <= mem_rdata;
    end else if (rd_load && avs_read && hit_nvcfg && idle) begin
      shadow_reg <= mem_rdata;
    end
  end

  // Divider registers; a programmed nonvolatile lock reloads as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divh_reg <= `DIVH_KEEP;
      divl_reg <= `NV_BLANK;
    end else if (boot_reg && boot_cnt_reg == `BOOT_LD_DIVH) begin
      divh_reg <= mem_rdata & `DIVH_KEEP;
    end else if (boot_reg && boot_cnt_reg == `BOOT_LD_DIVL) begin
      divl_reg <= mem_rdata;
    end else begin
      if (divh_wr) begin
        divh_reg <= wd & `DIVH_KEEP;
      end
      if (divl_wr) begin
        divl_reg <= wd;
      end
    end
  end

  // Control bits change only while idle; clearing go keeps latch set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_reg <= `CTL_RESET;
    end else if (wr_acc && hit_ctl && idle) begin
      ctl_reg <= wd & `CTL_WMASK;
    end
  end

  // Latch target; bus writes never reach the store directly
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lat_idx_reg   <= `IX_NV_CONFIG;
      lat_data_reg  <= `NV_BLANK;
      lat_valid_reg <= 1'b0;
    end else if (!ctl_reg[`CTL_LATCH]) begin
      lat_valid_reg <= 1'b0;
    end else if (wr_acc && hit_mem && idle) begin
      lat_idx_reg   <= bus_idx;
      lat_data_reg  <= wd;
      lat_valid_reg <= 1'b1;
    end
  end

  // Program/erase sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg     <= st_idle;
      refused_reg   <= 1'b0;
      pump_reg      <= 1'b0;
      auto_cnt_reg  <= 3'h0;
      sweep_idx_reg <= `ARR_FIRST;
    end else begin
      case (state_reg)
        st_idle: begin
          if (start) begin
            state_reg    <= st_run;
            refused_reg  <= prot_hit;
            pump_reg     <= ~prot_hit;
            auto_cnt_reg <= 3'h0;
          end
        end
        st_run: begin
          if (tick) begin
            auto_cnt_reg <= auto_cnt_reg + 3'h1;
          end
          if (stop_sw || stop_au) begin
            state_reg <= st_apply;
            pump_reg  <= 1'b0;
          end
        end
        st_apply: begin
          if (wide && !refused_reg) begin
            state_reg     <= st_sweep;
            sweep_idx_reg <= (mode == em_bulk) ? `ARR_FIRST : {blk, `BLK_FIRST};
          end else begin
            state_reg <= st_idle;
          end
        end
        st_sweep: begin
          sweep_idx_reg <= sweep_idx_reg + 9'h001;
          if (sw_last) begin
            state_reg <= st_idle;
          end
        end
        default: begin
          state_reg <= st_idle;
          pump_reg  <= 1'b0;
        end
      endcase
    end
  end

  assign avs_readdata    = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign charge_pump_on  = pump_reg;

  // Go without latch leaves the engine idle
  property p_go_needs_latch;
    @(posedge clk) disable iff (reset)
    (go_write && idle && !ctl_reg[`CTL_LATCH]) |=> (state_reg == st_idle);
  endproperty
  a_go_needs_latch: assert property (p_go_needs_latch)
    else $error("go started without latch");

  // A refused operation never powers the pump
  property p_pump_refused;
    @(posedge clk) disable iff (reset)
    (start && prot_hit) |=> (!charge_pump_on && running) ##1 !charge_pump_on;
  endproperty
  a_pump_refused: assert property (p_pump_refused)
    else $error("pump on for protected target");

  // Unused high divider bits always zero
  property p_divh_zero;
    @(posedge clk) disable iff (reset)
    !boot_reg |-> (divh_reg[6:3] == 4'h0);
  endproperty
  a_divh_zero: assert property (p_divh_zero)
    else $error("divider high bits 6:3 not zero");

  // Locked divider ignores writes
  property p_div_locked;
    @(posedge clk) disable iff (reset)
    (wr_acc && (hit_divh || hit_divl) && locked) |=> ($stable(divh_reg) && $stable(divl_reg));
  endproperty
  a_div_locked: assert property (p_div_locked)
    else $error("locked divider changed");

  // Programming never turns a zero into a one
  property p_program_clears;
    @(posedge clk) disable iff (reset)
    (mem_we && !in_sweep && mode == em_program) |-> ((mem_wdata & ~mem_rdata) == `ZERO8);
  endproperty
  a_program_clears: assert property (p_program_clears)
    else $error("program set a bit");

  // Armed secure region and config byte are never written
  property p_secure_frozen;
    @(posedge clk) disable iff (reset)
    (mem_we && armed) |-> !((mem_waddr[9:4] == {1'b0, `SEC_ROW}) || (mem_waddr == `IX_NV_CONFIG));
  endproperty
  a_secure_frozen: assert property (p_secure_frozen)
    else $error("secured cell written");

  // No sweep runs while armed or over a protected block
  property p_no_wide_armed;
    @(posedge clk) disable iff (reset)
    in_sweep |-> (!armed && !shadow_reg[sweep_idx_reg[8:7]]);
  endproperty
  a_no_wide_armed: assert property (p_no_wide_armed)
    else $error("sweep while armed or protected");

  // Config read refreshes the shadow with the stored byte
  property p_shadow_refresh;
    @(posedge clk) disable iff (reset)
    (rd_load && avs_read && hit_nvcfg && idle) |=> (shadow_reg == $past(mem_rdata));
  endproperty
  a_shadow_refresh: assert property (p_shadow_refresh)
    else $error("shadow not refreshed");
endmodule // ee_config_protect

// *** bench/tb.sv ***
// Self-checking testbench for the EEPROM configuration and protection block
`include "ee_config_consts.svh"
module tb;
  import ee_config_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;              // Bus clock
  logic        reset;            // Async reset, active high
  logic [15:0] avs_address;      // Word address
  logic        avs_read;         // Read strobe
  logic        avs_write;        // Write strobe
  logic [31:0] avs_writedata;    // Low lane used
  logic [31:0] avs_readdata;     // Read data
  logic        avs_waitrequest;  // Slave stall
  logic        charge_pump_on;   // Pump indicator
  logic        xtal;             // Crystal reference pin
  logic        ref_sel;          // Reference select strap, 1 = crystal
  logic [7:0]  q;                // Scratch read value
  int          fails;            // Mismatch count
  int          num_checks;       // Comparison count

  // 4 MHz crystal times 35 us, plus one half, truncated
  localparam logic [7:0] xtal_div = 8'h8C;

  ee_config_protect dut_u (
    .clk                 (clk),
    .reset               (reset),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (4'hF),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .crystal_ref_clock   (xtal),
    .timebase_ref_select (ref_sel),
    .charge_pump_on      (charge_pump_on)
  );

  // Free-running bus clock
  always #5 clk = ~clk;

  // 4 MHz crystal, well below half the bus clock so no edge is lost
  always #125 xtal = ~xtal;

  // Byte comparison with report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Elapsed-time comparison against a window; unknown counts as a miss
  task automatic chk_time(input time got, input time lo, input time hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // One Avalon transfer; an edge always passes before a new request
  // Waits for the answer however long; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] rd);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    bus(1'b0, a, 8'h00, d);
  endtask

  // Full program/erase sequence; auto mode polls go, manual clears it
  task automatic op(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d,
                    input logic pump);
    logic [7:0] x;
    int n;
    wr(`A_CONTROL, ctl);
    wr(a, d);
    wr(`A_CONTROL, ctl | 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h0, charge_pump_on}, {7'h0, pump});
    if (ctl[1]) begin
      n = 0;
      do begin
        rd(`A_CONTROL, x);
        n++;
      end while (x[0] !== 1'b0 && n < 8000);
      chk(x, ctl);
    end else begin
      wr(`A_CONTROL, ctl);
    end
    // Longest sweep is 512 cycles
    repeat (520) @(posedge clk);
    wr(`A_CONTROL, 8'h00);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask

  // Values copied in at reset, read-only shadow, reserved bits
  task automatic t_reset_values();
    rd(`A_SHADOW, q);    chk(q, 8'hF0);
    wr(`A_SHADOW, 8'h00);
    rd(`A_SHADOW, q);    chk(q, 8'hF0);
    rd(`A_DIV_HIGH, q);  chk(q, 8'h87);
    wr(`A_DIV_HIGH, 8'hFF);
    rd(`A_DIV_HIGH, q);  chk(q, 8'h87);
    rd(`A_DIV_LOW, q);   chk(q, 8'hFF);
    rd(`A_CONTROL, q);   chk(q, 8'h00);
    rd(16'h0700, q);     chk(q, 8'h00);
    wr(`A_CONTROL, 8'h01);
    rd(`A_CONTROL, q);   chk(q, 8'h00);
    wr(`A_NV_CONFIG, 8'h00);
    rd(`A_NV_CONFIG, q); chk(q, 8'hF0);
    $display("test reset_values done");
  endtask

  // Program ANDs bits in; erase and block protect
  task automatic t_program_protect();
    op(8'h04, 16'h0800, 8'h0F, 1'b1);
    op(8'h04, 16'h0800, 8'hF3, 1'b1);
    rd(16'h0800, q);     chk(q, 8'h03);
    op(8'h0C, `A_NV_CONFIG, 8'h00, 1'b1);
    rd(`A_NV_CONFIG, q); chk(q, 8'hFF);
    rd(`A_SHADOW, q);    chk(q, 8'hFF);
    op(8'h04, 16'h0800, 8'h00, 1'b0);
    rd(16'h0800, q);     chk(q, 8'h03);
    op(8'h04, `A_NV_CONFIG, 8'hF0, 1'b1);
    rd(`A_NV_CONFIG, q); chk(q, 8'hF0);
    op(8'h0C, 16'h0800, 8'h00, 1'b1);
    rd(16'h0800, q);     chk(q, 8'hFF);
    // Block erase of block 0 must stop at its end; bulk clears the rest
    op(8'h04, 16'h087F, 8'h00, 1'b1);
    op(8'h04, 16'h0880, 8'h00, 1'b1);
    op(8'h14, 16'h0800, 8'h00, 1'b1);
    rd(16'h087F, q);     chk(q, 8'hFF);
    rd(16'h0880, q);     chk(q, 8'h00);
    op(8'h1C, 16'h0900, 8'h00, 1'b1);
    rd(16'h0880, q);     chk(q, 8'hFF);
    $display("test program_protect done");
  endtask

  // Arm the secure region and probe what stays allowed
  task automatic t_secure();
    op(8'h04, `A_NV_CONFIG, 8'hE0, 1'b1);
    rd(`A_NV_CONFIG, q); chk(q, 8'hE0);
    op(8'h04, 16'h08F0, 8'h00, 1'b0);
    rd(16'h08F0, q);     chk(q, 8'hFF);
    op(8'h06, 16'h0900, 8'h00, 1'b1);
    rd(16'h0900, q);     chk(q, 8'h00);
    op(8'h14, 16'h0900, 8'h00, 1'b0);
    rd(16'h0900, q);     chk(q, 8'h00);
    op(8'h04, `A_NV_CONFIG, 8'h00, 1'b0);
    rd(`A_NV_CONFIG, q); chk(q, 8'hE0);
    $display("test secure done");
  endtask

  // Crystal reference: an auto op lasts the chosen count of 35 us ticks
  // The window also covers the op task's tail of about 5.3 us of settling
  task automatic t_timebase();
    time t0;
    ref_sel <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`A_DIV_HIGH, 8'h80);
    wr(`A_DIV_LOW, xtal_div);
    t0 = $time;
    op(8'h06, 16'h0980, 8'h00, 1'b1);
    chk_time($time - t0, `AUTO_TICKS * `TIMEBASE_NS,
             `AUTO_TICKS * `TIMEBASE_NS + 10000);
    rd(16'h0980, q);     chk(q, 8'h00);
    $display("test timebase done");
  endtask

  // Lock the divider permanently through the option byte
  task automatic t_divider_lock();
    wr(`A_DIV_LOW, 8'h5A);
    rd(`A_DIV_LOW, q);   chk(q, 8'h5A);
    op(8'h04, `A_DIV_NV_HIGH, 8'h7F, 1'b1);
    do_reset();
    rd(`A_DIV_HIGH, q);  chk(q, 8'h07);
    rd(`A_SHADOW, q);    chk(q, 8'hE0);
    wr(`A_DIV_LOW, 8'h11);
    rd(`A_DIV_LOW, q);   chk(q, 8'hFF);
    op(8'h04, `A_DIV_NV_LOW, 8'h00, 1'b0);
    rd(`A_DIV_NV_LOW, q); chk(q, 8'hFF);
    $display("test divider_lock done");
  endtask

  // Single place where the run ends
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk           = 1'b0;
    reset         = 1'b1;
    avs_address   = 16'h0000;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
    fails         = 0;
    num_checks    = 0;
    xtal          = 1'b0;
    ref_sel       = 1'b0;
    do_reset();
    t_reset_values();
    t_program_protect();
    t_secure();
    t_timebase();
    t_divider_lock();
    end_of_test();
  end

  // Watchdog: tests need about 32000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule // tb
